// ### byte_stream_if.sv
// valid/ready stream carrier between the packer and its fifo
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### raw_frame_record_packer.sv
// packs bus frames into a continuous raw record byte stream
`timescale 1ns/1ns
module raw_frame_record_packer (
  input wire logic ref_clk,
  input wire logic rst_b,
  // avalon-mm slave, word addressed
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // frame descriptor from the bus controllers
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [3:0] frm_proto,
  input wire logic [3:0] frm_subtype,
  input wire logic frm_ext,
  input wire logic [28:0] frm_id,
  input wire logic frm_echo,
  input wire logic [6:0] frm_flags,
  input wire logic [7:0] frm_info,
  input wire logic [7:0] frm_len,
  // payload data bytes of the accepted frame
  input wire logic pl_valid,
  output logic pl_ready,
  input wire logic [7:0] pl_data,
  // record byte stream to the consumer
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  localparam int LW = $clog2(record_packer_pkg::FIFO_DEPTH + 1);
  localparam logic [7:0] ACC_STEP = 8'(record_packer_pkg::CLK_PERIOD_NS);
  localparam logic [7:0] ACC_WRAP = 8'(record_packer_pkg::TS_UNIT_NS);
  localparam logic [3:0] HDR_LAST = 4'(record_packer_pkg::HDR_BYTES - 1);
  localparam logic [8:0] UNIT_MASK = 9'(record_packer_pkg::UNIT_BYTES - 1);

  typedef struct packed {
    record_packer_pkg::pk_state_t st;
    logic [127:0] hdr;
    logic [3:0] hidx;
    logic [7:0] plen;
    logic [8:0] total;
    logic [8:0] ecnt;
    logic [8:0] acnt;
    logic [7:0] pb;
    logic pb_full;
    logic frm_ready;
    logic pl_ready;
    logic [63:0] ts;
    logic [7:0] ns_acc;
    logic [63:0] ts_stage;
    logic [1:0] ctrl;
    logic [15:0] frames;
    logic waitreq;
    logic [31:0] rdata;
    logic out_valid;
    logic [7:0] out_data;
  } top_st_t;

  top_st_t r;
  top_st_t n;
  logic [LW-1:0] fifo_level;
  logic [31:0] id_word;
  logic [7:0] flags_byte;
  logic [7:0] info_byte;
  logic [63:0] ts_field;
  logic [31:0] id_field;
  logic [7:0] emit_byte;
  logic emit_valid;
  logic pay_data;
  logic push;

  byte_stream_if #(.WIDTH(8)) fin ();
  byte_stream_if #(.WIDTH(8)) fout ();

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [63:0] swap64(input logic [63:0] v);
    logic [63:0] s;
    s = '0;
    for (int i = 0; i < 8; i++) begin
      s[8*i +: 8] = v[8*(7-i) +: 8];
    end
    return s;
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] v);
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 4; i++) begin
      s[8*i +: 8] = v[8*(3-i) +: 8];
    end
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction

  // -------------------------------------------------------------
  // field encoding of the incoming descriptor
  // -------------------------------------------------------------
  // identifier keeps only the bits its protocol owns, the rest stay zero
  always_comb begin
    id_word = '0;
    flags_byte = '0;
    info_byte = '0;
    flags_byte[record_packer_pkg::ECHO_BIT] = frm_echo;
    if (frm_proto == record_packer_pkg::PROTO_CAN) begin
      if (frm_ext) begin
        id_word[record_packer_pkg::CAN_EXT_BITS-1:0] = frm_id;
        id_word[record_packer_pkg::ID_EXT_BIT] = 1'b1;
      end else begin
        id_word[record_packer_pkg::CAN_STD_BITS-1:0] =
          frm_id[record_packer_pkg::CAN_STD_BITS-1:0];
      end
    end else if (frm_proto == record_packer_pkg::PROTO_FLEXRAY) begin
      id_word[record_packer_pkg::FR_SLOT_BITS-1:0] =
        frm_id[record_packer_pkg::FR_SLOT_BITS-1:0];
      flags_byte[6:0] = frm_flags & record_packer_pkg::FLAGS_FR_MASK;
      info_byte[record_packer_pkg::FR_CYCLE_BITS-1:0] =
        frm_info[record_packer_pkg::FR_CYCLE_BITS-1:0];
    end else if (frm_proto == record_packer_pkg::PROTO_LIN) begin
      id_word[record_packer_pkg::LIN_ID_BITS-1:0] =
        frm_id[record_packer_pkg::LIN_ID_BITS-1:0];
      flags_byte[6:0] = frm_flags & record_packer_pkg::FLAGS_LIN_MASK;
      if (frm_flags[0]) begin
        info_byte = frm_info;
      end
    end else begin
      // special records keep the full descriptor
      id_word[record_packer_pkg::CAN_EXT_BITS-1:0] = frm_id;
      flags_byte[6:0] = frm_flags;
      info_byte = frm_info;
    end
  end

  // host byte order chosen by software for both wide fields
  assign ts_field = r.ctrl[record_packer_pkg::CTRL_BE] ? swap64(r.ts) : r.ts;
  assign id_field = r.ctrl[record_packer_pkg::CTRL_BE] ? swap32(id_word) : id_word;

  // -------------------------------------------------------------
  // byte emitter
  // -------------------------------------------------------------
  // header bytes walk upward from the record start; payload pads with zero
  always_comb begin
    pay_data = (r.ecnt < {1'b0, r.plen});
    emit_byte = '0;
    emit_valid = 1'b0;
    if (r.st == record_packer_pkg::ST_HDR) begin
      emit_byte = r.hdr[{r.hidx, 3'b000} +: 8];
      emit_valid = 1'b1;
    end else if (r.st == record_packer_pkg::ST_PAY) begin
      emit_byte = pay_data ? r.pb : 8'h00;
      emit_valid = pay_data ? r.pb_full : 1'b1;
    end
  end

  assign fin.valid = emit_valid;
  assign fin.data = emit_byte;
  assign push = emit_valid && fin.ready;
  assign fout.ready = !r.out_valid || out_ready;

  stream_fifo #(
    .WIDTH(8),
    .DEPTH(record_packer_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fill(fin),
    .drain(fout),
    .level(fifo_level)
  );

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    n = r;
    // fractional tick: 100 ns is two and a half clocks, so carry the remainder
    if (r.ns_acc + ACC_STEP >= ACC_WRAP) begin
      n.ns_acc = r.ns_acc + ACC_STEP - ACC_WRAP;
      n.ts = r.ts + 64'h1;
    end else begin
      n.ns_acc = r.ns_acc + ACC_STEP;
    end

    // register slave: one wait cycle, then answer with waitrequest low
    n.waitreq = !((avs_read || avs_write) && r.waitreq);
    if (avs_read && r.waitreq) begin
      if (avs_address == record_packer_pkg::REG_CTRL) begin
        n.rdata = {30'h0, r.ctrl};
      end else if (avs_address == record_packer_pkg::REG_TS_LO) begin
        n.rdata = r.ts[31:0];
      end else if (avs_address == record_packer_pkg::REG_TS_HI) begin
        n.rdata = r.ts[63:32];
      end else if (avs_address == record_packer_pkg::REG_STATUS) begin
        n.rdata = '0;
        n.rdata[record_packer_pkg::STAT_BUSY] = (r.st != record_packer_pkg::ST_IDLE);
        n.rdata[record_packer_pkg::STAT_PB_FULL] = r.pb_full;
        n.rdata[record_packer_pkg::STAT_LVL_LSB +: LW] = fifo_level;
      end else if (avs_address == record_packer_pkg::REG_FRAMES) begin
        n.rdata = {16'h0, r.frames};
      end else begin
        n.rdata = record_packer_pkg::WAIT_RST;
      end
    end
    if (avs_write && !r.waitreq) begin
      if (avs_address == record_packer_pkg::REG_CTRL) begin
        if (avs_byteenable[0]) begin
          n.ctrl = avs_writedata[1:0];
          // absolute time is set by software from the staged halves
          if (avs_writedata[record_packer_pkg::CTRL_TS_LOAD]) begin
            n.ts = r.ts_stage;
            n.ns_acc = '0;
          end
        end
      end else if (avs_address == record_packer_pkg::REG_TS_LO) begin
        n.ts_stage[31:0] = merge(r.ts_stage[31:0], avs_writedata, avs_byteenable);
      end else if (avs_address == record_packer_pkg::REG_TS_HI) begin
        n.ts_stage[63:32] = merge(r.ts_stage[63:32], avs_writedata, avs_byteenable);
      end else if (avs_address == record_packer_pkg::REG_FRAMES) begin
        n.frames = '0;
      end
    end

    // record sequencer
    case (r.st)
      record_packer_pkg::ST_IDLE: begin
        if (frm_valid && r.frm_ready) begin
          n.hdr = '0;
          n.hdr[8*record_packer_pkg::OFS_TS +: 64] = ts_field;
          n.hdr[8*record_packer_pkg::OFS_ID +: 32] = id_field;
          n.hdr[8*record_packer_pkg::OFS_TYPE +: 8] = {frm_proto, frm_subtype};
          n.hdr[8*record_packer_pkg::OFS_FLAGS +: 8] = flags_byte;
          n.hdr[8*record_packer_pkg::OFS_INFO +: 8] = info_byte;
          n.hdr[8*record_packer_pkg::OFS_LEN +: 8] = frm_len;
          n.plen = frm_len;
          // payload rounds up to whole units
          n.total = ({1'b0, frm_len} + UNIT_MASK) & ~UNIT_MASK;
          n.hidx = '0;
          n.ecnt = '0;
          n.acnt = '0;
          n.st = record_packer_pkg::ST_HDR;
        end
      end
      record_packer_pkg::ST_HDR: begin
        if (push) begin
          n.hidx = r.hidx + 4'h1;
          if (r.hidx == HDR_LAST) begin
            if (r.total == '0) begin
              n.st = record_packer_pkg::ST_IDLE;
              n.frames = n.frames + 16'h1;
            end else begin
              n.st = record_packer_pkg::ST_PAY;
            end
          end
        end
      end
      record_packer_pkg::ST_PAY: begin
        if (push) begin
          if (pay_data) begin
            n.pb_full = 1'b0;
          end
          n.ecnt = r.ecnt + 9'h1;
          if (r.ecnt == r.total - 9'h1) begin
            n.st = record_packer_pkg::ST_IDLE;
            n.frames = n.frames + 16'h1;
          end
        end
      end
      default: begin
        n.st = record_packer_pkg::ST_IDLE;
      end
    endcase

    // payload byte holding register, filled ahead of the emitter
    if (pl_valid && r.pl_ready) begin
      n.pb = pl_data;
      n.pb_full = 1'b1;
      n.acnt = r.acnt + 9'h1;
    end
    n.pl_ready = (n.st != record_packer_pkg::ST_IDLE) && (n.acnt < {1'b0, n.plen}) &&
                 !n.pb_full;
    n.frm_ready = n.ctrl[record_packer_pkg::CTRL_EN] && (n.st == record_packer_pkg::ST_IDLE);

    // registered output stage so the consumer sees flop outputs
    if (fout.valid && fout.ready) begin
      n.out_valid = 1'b1;
      n.out_data = fout.data;
    end else if (out_ready) begin
      n.out_valid = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= record_packer_pkg::ST_IDLE;
      r.ctrl <= record_packer_pkg::CTRL_RST;
      r.waitreq <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign frm_ready = r.frm_ready;
  assign pl_ready = r.pl_ready;
  assign out_valid = r.out_valid;
  assign out_data = r.out_data;
endmodule

// ### raw_frame_record_packer_monitor.sv
// port checker for the frame record packer, bound to its top
`timescale 1ns/1ns
module raw_frame_record_packer_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic pl_valid,
  input wire logic pl_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data
);
  // ---------------------------------------
  // sequences
  // ---------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // access taken while the slave still waits
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // descriptor accepted by the packer
  sequence s_take;
    frm_valid && frm_ready;
  endsequence
  // ---------------------------------------
  // properties
  // ---------------------------------------
  property p_ans;
    s_req |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("bus access not answered");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_take;
    s_take |=> !frm_ready;
  endproperty
  a_take: assert property (p_take) else $error("second frame taken mid record");
  property p_start;
    s_take |-> ##[1:8] out_valid;
  endproperty
  a_start: assert property (p_start) else $error("record did not start");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_pl;
    pl_valid && pl_ready |=> !pl_ready;
  endproperty
  a_pl: assert property (p_pl) else $error("payload ready did not drop");
  property p_idle;
    frm_ready |-> !pl_ready;
  endproperty
  a_idle: assert property (p_idle) else $error("payload taken while idle");
  // reset must clear the stream even though the default disable is reset
  property p_rst;
    disable iff (1'b0) !rst_b |=> !out_valid && !frm_ready && !pl_ready && avs_waitrequest;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind raw_frame_record_packer raw_frame_record_packer_monitor i_mon (
  .ref_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .frm_valid,
  .frm_ready, .pl_valid, .pl_ready, .out_valid, .out_ready, .out_data
);

// ### raw_frame_record_packer_tb.sv
// self-checking bench for the frame record packer
`timescale 1ns/1ns
module raw_frame_record_packer_tb;
  typedef struct packed {
    logic [3:0] pr;
    logic [3:0] st;
    logic ext;
    logic echo;
    logic [28:0] id;
    logic [6:0] fl;
    logic [7:0] inf;
    logic [7:0] len;
    logic [31:0] xid;
    logic [7:0] xfl;
    logic [7:0] xinf;
  } row_t;
  // ---------------------------------------
  // signals and rows
  // ---------------------------------------
  localparam logic [31:0] TS_HI_V = 32'h01D9A5C3;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic frm_valid, frm_ready, pl_valid, pl_ready, out_valid, out_ready;
  logic [2:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat, t0;
  logic [7:0] pl_data, out_data;
  logic [1:0] stall;
  logic [63:0] ts_prev;
  row_t cur;
  int error_cnt, num_checks, cyc, base, el;
  time tm;
  // one row per protocol corner: inputs, then expected id, flags, info
  row_t rows [6] = '{
    '{4'h0, 4'h1, 1'b0, 1'b0, 29'h1FFFFFFF, 7'h7F, 8'hAA, 8'h03, 32'h000007FF, 8'h00, 8'h00},
    '{4'h0, 4'h2, 1'b1, 1'b1, 29'h1FFFFFFF, 7'h7F, 8'h00, 8'h08, 32'h3FFFFFFF, 8'h80, 8'h00},
    '{4'h2, 4'h3, 1'b0, 1'b0, 29'h0ABC4567, 7'h7F, 8'hFF, 8'h00, 32'h00004567, 8'h37, 8'h3F},
    '{4'h4, 4'h5, 1'b0, 1'b1, 29'h000001FF, 7'h03, 8'h55, 8'h01, 32'h0000003F, 8'h81, 8'h55},
    '{4'h4, 4'h6, 1'b0, 1'b0, 29'h00000005, 7'h02, 8'h33, 8'h10, 32'h00000005, 8'h00, 8'h00},
    '{4'hE, 4'h7, 1'b0, 1'b0, 29'h1ABCDEF0, 7'h15, 8'h99, 8'h09, 32'h1ABCDEF0, 8'h15, 8'h99}
  };
  raw_frame_record_packer i_raw_frame_record_packer (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .frm_valid, .frm_ready,
    .frm_proto(cur.pr), .frm_subtype(cur.st), .frm_ext(cur.ext), .frm_id(cur.id),
    .frm_echo(cur.echo), .frm_flags(cur.fl), .frm_info(cur.inf), .frm_len(cur.len),
    .pl_valid, .pl_ready, .pl_data, .out_valid, .out_ready, .out_data
  );
  record_sink i_sink (.ref_clk, .rst_b, .stall, .out_valid, .out_data, .out_ready);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard: the run needs under two thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  // ---------------------------------------
  // tasks
  // ---------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low, then one idle edge
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    av(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic send(input row_t r);
    cur <= r;
    frm_valid <= 1'b1;
    @(posedge ref_clk);
    while (frm_ready !== 1'b1) @(posedge ref_clk);
    frm_valid <= 1'b0;
    for (int k = 0; k < int'(r.len); k++) begin
      pl_valid <= 1'b1;
      pl_data <= {r.st, 4'(k)};
      @(posedge ref_clk);
      while (pl_ready !== 1'b1) @(posedge ref_clk);
    end
    pl_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  // assemble a field from the stream in either byte order
  function automatic logic [63:0] pick(input int b, input int n, input logic be);
    logic [63:0] v;
    v = 64'h0;
    for (int i = 0; i < n; i++)
      v = be ? {v[55:0], i_sink.got[b + i]} : v | (64'(i_sink.got[b + i]) << (8 * i));
    return v;
  endfunction
  task automatic chk_rec(input row_t r, input logic be);
    int pad;
    logic [63:0] ts;
    pad = ((int'(r.len) + 7) / 8) * 8;
    ts = pick(base, 8, be);
    chk({32'h0, ts[63:32]}, {32'h0, TS_HI_V});
    chk(64'(ts > ts_prev), 64'h1);
    ts_prev = ts;
    chk(pick(base + 8, 4, be), {32'h0, r.xid});
    chk(pick(base + 12, 2, 1'b1), {48'h0, r.pr, r.st, r.xfl});
    chk(pick(base + 14, 2, 1'b1), {48'h0, r.xinf, r.len});
    for (int k = 0; k < pad; k++)
      chk(64'(i_sink.got[base + 16 + k]),
          (k < int'(r.len)) ? 64'({r.st, 4'(k)}) : 64'h0);
    base += 16 + pad;
  endtask
  // ---------------------------------------
  // main sequence
  // ---------------------------------------
  initial begin
    rst_b = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    frm_valid = 1'b0;
    cur = '0;
    pl_valid = 1'b0;
    pl_data = 8'h0;
    stall = 2'h0;
    ts_prev = 64'h0;
    repeat (8) @(posedge ref_clk);
    chk({61'h0, out_valid, frm_ready, avs_waitrequest}, 64'h1);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(record_packer_pkg::REG_CTRL);
    chk(64'(rdat), 64'h0);
    // enable lives in lane 0 only, so this write is dropped
    av(1'b1, record_packer_pkg::REG_CTRL, 32'h1, 4'hE);
    rd(record_packer_pkg::REG_CTRL);
    chk(64'(rdat), 64'h0);
    av(1'b1, 3'h6, 32'hFFFFFFFF, 4'hF);
    rd(3'h6);
    chk(64'(rdat), 64'h0);
    // load absolute time, then measure the tick rate against sim time
    av(1'b1, record_packer_pkg::REG_TS_LO, 32'h0, 4'hF);
    av(1'b1, record_packer_pkg::REG_TS_HI, TS_HI_V, 4'hF);
    av(1'b1, record_packer_pkg::REG_CTRL, 32'h4, 4'hF);
    rd(record_packer_pkg::REG_TS_HI);
    chk(64'(rdat), 64'(TS_HI_V));
    rd(record_packer_pkg::REG_TS_LO);
    t0 = rdat;
    tm = $time;
    repeat (1000) @(posedge ref_clk);
    rd(record_packer_pkg::REG_TS_LO);
    el = int'(rdat - t0) - int'(($time - tm) / 100);
    chk(64'(el >= -1 && el <= 1), 64'h1);
    $display("test registers done");
    av(1'b1, record_packer_pkg::REG_CTRL, 32'h1, 4'hF);
    stall <= 2'h1;
    foreach (rows[i]) send(rows[i]);
    while (i_sink.recs < 6) @(posedge ref_clk);
    foreach (rows[i]) chk_rec(rows[i], 1'b0);
    rd(record_packer_pkg::REG_FRAMES);
    chk(64'(rdat), 64'h6);
    // any write to the frame counter clears it
    av(1'b1, record_packer_pkg::REG_FRAMES, 32'h0, 4'hF);
    rd(record_packer_pkg::REG_FRAMES);
    chk(64'(rdat), 64'h0);
    $display("test rows done");
    // blocked consumer: fifo fills, frame held back; then big endian drain
    stall <= 2'h2;
    av(1'b1, record_packer_pkg::REG_CTRL, 32'h3, 4'hF);
    fork
      send(rows[4]);
    join_none
    do rd(record_packer_pkg::REG_STATUS);
    while (rdat[12:8] !== 5'(record_packer_pkg::FIFO_DEPTH));
    chk({62'h0, frm_ready, rdat[0]}, 64'h1);
    stall <= 2'h0;
    while (i_sink.recs < 7) @(posedge ref_clk);
    chk_rec(rows[4], 1'b1);
    rd(record_packer_pkg::REG_STATUS);
    chk(64'(rdat[12:8]), 64'h0);
    rd(record_packer_pkg::REG_FRAMES);
    chk(64'(rdat), 64'h1);
    $display("test fifo fill done");
    finish_test;
  end
endmodule

// ### record_packer_pkg.sv
// constants, field layout and types for the frame record packer
//
// Operation
// - one base unit plus payload units, back to back
// - field offsets count from each record start
// - bytes 0-7 hold 64-bit 100 ns timestamp
// - timestamp absolute, counted from epoch midnight UTC
// - multi-byte fields follow host byte order
// - bytes 8-11 hold 32-bit identifier
// - CAN identifier bit 29 marks extended format
// - CAN id in bits 0-10 or 0-28
// - FlexRay slot number in low 16 bits
// - LIN identifier is unprotected id 0-63
// - unused identifier bits written as zero
// - byte 12 upper nibble is protocol code
// - type byte lower nibble is specific type
// - byte 13 flags, bit 7 marks echo
// - byte 14 info, FlexRay cycle count 0-63
// - byte 15 gives payload data byte count
package record_packer_pkg;
  // -------------------------------------------------------------
  // record layout
  // -------------------------------------------------------------
  localparam int HDR_BYTES = 16;
  localparam int UNIT_BYTES = 8;
  localparam int OFS_TS = 0;
  localparam int OFS_ID = 8;
  localparam int OFS_TYPE = 12;
  localparam int OFS_FLAGS = 13;
  localparam int OFS_INFO = 14;
  localparam int OFS_LEN = 15;
  localparam int ID_EXT_BIT = 29;
  localparam int CAN_STD_BITS = 11;
  localparam int CAN_EXT_BITS = 29;
  localparam int FR_SLOT_BITS = 16;
  localparam int LIN_ID_BITS = 6;
  localparam int FR_CYCLE_BITS = 6;
  localparam int ECHO_BIT = 7;
  localparam logic [3:0] PROTO_CAN = 4'h0;
  localparam logic [3:0] PROTO_FLEXRAY = 4'h2;
  localparam logic [3:0] PROTO_LIN = 4'h4;
  localparam logic [3:0] PROTO_SPECIAL = 4'hE;
  localparam logic [6:0] FLAGS_FR_MASK = 7'h37;
  localparam logic [6:0] FLAGS_LIN_MASK = 7'h01;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int TS_UNIT_NS = 100;
  localparam int CLK_PERIOD_NS = 40;
  // -------------------------------------------------------------
  // register map (word index, byte address is four times it)
  // -------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TS_LO = 3'h1;
  localparam logic [2:0] REG_TS_HI = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_FRAMES = 3'h4;
  localparam int CTRL_EN = 0;
  localparam int CTRL_BE = 1;
  localparam int CTRL_TS_LOAD = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PB_FULL = 1;
  localparam int STAT_LVL_LSB = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [31:0] WAIT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_PAY = 2'b11
  } pk_state_t;
endpackage

// ### record_sink.sv
// consumer model: takes the record stream, stalls on request, counts records
`timescale 1ns/1ns
module record_sink (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [1:0] stall,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] got[$];
  logic [1:0] ph;
  int ofs;
  int rec_len;
  int recs;
  // ---------------------------------------
  // stall pattern and record delimiting
  // ---------------------------------------
  // ready is registered, so a stall always starts on a clock edge
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ph <= 2'h0;
      out_ready <= 1'b0;
      ofs = 0;
      rec_len = 16;
      recs = 0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      out_ready <= (stall == 2'h0) || (stall == 2'h1 && ph == 2'h0);
      if (out_valid && out_ready) begin
        got.push_back(out_data);
        // the length byte decides where this record ends
        if (ofs == 15)
          rec_len = 16 + ((int'(out_data) + 7) / 8) * 8;
        if (ofs == rec_len - 1) begin
          ofs = 0;
          recs++;
        end else begin
          ofs++;
        end
      end
    end
  end
endmodule

// ### stream_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  byte_stream_if.snk fill,
  byte_stream_if.src drain,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("stream_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t n;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign fill.ready = (r.cnt != CW'(DEPTH));
  assign drain.valid = (r.cnt != '0);
  assign drain.data = r.mem[r.rp];
  assign level = r.cnt;
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = fill.data;
      n.wp = r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = r.rp + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - CW'(1);
    end
  end

  // storage is not reset, only the pointers and the count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r.wp <= '0;
      r.rp <= '0;
      r.cnt <= '0;
      r.mem <= n.mem;
    end else begin
      r <= n;
    end
  end
endmodule
